/* hw/cms_pkg.sv */
package cms_pkg;
   // ****************************************
   // Register map and bus answers
   // ****************************************
   localparam logic [7:0] OFF_MODULE_CONFIG = 8'h00;
   localparam logic [7:0] OFF_SYS_PROTECT = 8'h04;
   localparam logic [7:0] OFF_PORT_E_ASSIGN = 8'h08;
   localparam logic [7:0] OFF_MEM_GLOBAL = 8'h0c;
   localparam logic [7:0] OFF_MEM_STATUS = 8'h10;
   localparam logic [7:0] OFF_WDOG_SERVICE = 8'h14;
   localparam logic [7:0] OFF_STRAP_STATUS = 8'h18;
   localparam logic [7:0] OFF_BANK_FIRST = 8'h20;
   localparam logic [7:0] OFF_BANK_LAST = 8'h5c;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [31:0] RESET_WORD = 32'h0;
   localparam logic [31:0] IARB_RESET = 32'h0000000f;
   // ****************************************
   // Field positions
   // ****************************************
   localparam int MCR_IARB_LO = 0;
   localparam logic [3:0] IARB_TOP = 4'hf;
   localparam int SYP_SWE = 7;
   localparam int SYP_WATCHDOG_RESET_OR_INTERRUPT = 6;
   localparam int GMR_REFRESH_INTERVAL_COUNT_LO = 24;
   localparam int GMR_REFRESH_ENABLE_BIT = 23;
   localparam int GMR_PARITY_BUS_ERROR_ENABLE = 4;
   localparam int STAT_WPER = 1;
   localparam int STAT_PER = 0;
   localparam int BR_BASE_LO = 11;
   localparam int BR_FC_LO = 7;
   localparam int BR_BANK_PARITY_ENABLE = 2;
   localparam int BR_WP = 1;
   localparam int BR_V = 0;
   localparam int OR_FCM_LO = 7;
   localparam int OR_BCYC_LO = 5;
   localparam int OR_DRAM_SELECT_BIT = 0;
   localparam logic [3:0] FC_CPU_SPACE = 4'h7;
   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_PERIOD_PS = 10000;
   localparam int REFRESH_PERIOD_PS = 15600000;
   localparam int REFRESH_REF_COUNT = 24;
   localparam int REFRESH_UNIT_CYCLES = REFRESH_PERIOD_PS / (REFRESH_REF_COUNT * CLK_PERIOD_PS);
endpackage

/* hw/cms_refresh.sv */
`timescale 1ns/1ps
module cms_refresh (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic enable,
   input wire logic [7:0] interval,
   output logic refresh_pulse_q
);
   logic [7:0] unit_q, unit_d;
   logic [7:0] count_q, count_d;
   logic refresh_pulse_d;

   // ****************************************
   // Interval timer
   // ****************************************
   // A zero interval stops refresh rather than hammering the array every unit.
   always_comb begin
      unit_d = unit_q;
      count_d = count_q;
      refresh_pulse_d = 1'b0;
      if (!enable || interval == 8'h0) begin
         unit_d = 8'h0;
         count_d = 8'h0;
      end else if (unit_q != 8'(cms_pkg::REFRESH_UNIT_CYCLES - 1)) begin
         unit_d = unit_q + 8'h1;
      end else begin
         unit_d = 8'h0;
         if (count_q == interval - 8'h1) begin
            count_d = 8'h0;
            refresh_pulse_d = 1'b1;
         end else begin
            count_d = count_q + 8'h1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         unit_q <= 8'h0;
         count_q <= 8'h0;
         refresh_pulse_q <= 1'b0;
      end else begin
         unit_q <= unit_d;
         count_q <= count_d;
         refresh_pulse_q <= refresh_pulse_d;
      end
   end

   logic [15:0] gap_q;
   logic seen_q;
   always_ff @(posedge aclk) begin
      if (!aresetn || !enable) begin
         gap_q <= 16'h0;
         seen_q <= 1'b0;
      end else if (refresh_pulse_q) begin
         gap_q <= 16'h0;
         seen_q <= 1'b1;
      end else begin
         gap_q <= gap_q + 16'h1;
      end
   end

   a_refresh_spacing: assert property (@(posedge aclk) disable iff (!aresetn)
      refresh_pulse_q && seen_q && $stable(interval) && $past(enable)
      |-> 32'(gap_q) == 32'(interval) * cms_pkg::REFRESH_UNIT_CYCLES - 1)
      else $error("refresh spacing wrong");
endmodule

/* hw/cms_top.sv */
// The AXI4-Lite register port and the address map were left to the implementer.
`timescale 1ns/1ps
module cms_top #(
   parameter int NUM_BANKS = 8,
   parameter int WATCHDOG_CYCLES = 2048
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic transfer_start_pin,
   input wire logic [31:0] host_addr,
   input wire logic [3:0] host_fc,
   input wire logic host_write,
   input wire logic parity_error_in,
   input wire logic [2:0] boot_configuration_straps,
   input wire logic [2:0] sim_irq_level,
   input wire logic [2:0] cpm_irq_level,
   output logic [NUM_BANKS-1:0] chip_select_n_q,
   output logic [NUM_BANKS-1:0] row_strobe_n_q,
   output logic [2:0] burst_clocks_q,
   output logic bus_error_q,
   output logic refresh_pulse_q,
   output logic [2:0] irq_level_q,
   output logic irq_from_sim_q,
   output logic watchdog_irq_q,
   output logic watchdog_reset_q,
   output logic [15:0] port_e_function_q
);
   generate
      if (NUM_BANKS < 1 || NUM_BANKS > 8 || WATCHDOG_CYCLES < 2 || WATCHDOG_CYCLES > 65535) begin : g_bad
         $error("cms_top parameters out of range");
      end
   endgenerate

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            r[b*8 +: 8] = nw[b*8 +: 8];
         end
      end
      return r;
   endfunction

   // ****************************************
   // Register state
   // ****************************************
   logic [31:0] mcr_q, mcr_d, gmr_q, gmr_d, status_q, status_d;
   logic [7:0] system_protection_control_q, system_protection_control_d;
   logic [15:0] port_e_pin_assignment_q, port_e_pin_assignment_d;
   logic [31:0] base_q [NUM_BANKS], base_d [NUM_BANKS];
   logic [31:0] opt_q [NUM_BANKS], opt_d [NUM_BANKS];
   logic [2:0] strap_q, strap_d;
   logic strap_taken_q, strap_taken_d;
   logic aw_have_q, aw_have_d, w_have_q, w_have_d, bvalid_d, rvalid_d;
   logic [7:0] awaddr_q, awaddr_d;
   logic [31:0] wdata_q, wdata_d, rdata_d;
   logic [3:0] wstrb_q, wstrb_d;
   logic [1:0] bresp_d, rresp_d;
   logic [15:0] wdog_q, wdog_d;
   logic last_bank_parity_enable_q, last_bank_parity_enable_d;
   logic [NUM_BANKS-1:0] cs_n_d, ras_n_d;
   logic [2:0] burst_d, irq_level_d;
   logic bus_error_d, irq_sim_d, wdog_irq_d, wdog_rst_d, do_write, service;
   logic ar_take, aw_take, w_take, wp_hit, par_hit;
   logic [3:0] bidx;

   assign aw_take = s_axi_awvalid && s_axi_awready;
   assign w_take = s_axi_wvalid && s_axi_wready;
   assign ar_take = s_axi_arvalid && s_axi_arready;
   assign do_write = aw_have_q && w_have_q && !s_axi_bvalid;

   // ****************************************
   // Bus slave and register file
   // ****************************************
   // Writes commit only once both halves are held, so address and data may arrive in either order.
   always_comb begin
      aw_have_d = aw_have_q;
      w_have_d = w_have_q;
      awaddr_d = awaddr_q;
      wdata_d = wdata_q;
      wstrb_d = wstrb_q;
      bvalid_d = s_axi_bvalid && !s_axi_bready;
      bresp_d = s_axi_bresp;
      rvalid_d = s_axi_rvalid && !s_axi_rready;
      rdata_d = s_axi_rdata;
      rresp_d = s_axi_rresp;
      mcr_d = mcr_q;
      gmr_d = gmr_q;
      system_protection_control_d = system_protection_control_q;
      port_e_pin_assignment_d = port_e_pin_assignment_q;
      base_d = base_q;
      opt_d = opt_q;
      service = 1'b0;
      status_d = status_q;
      bidx = 4'((awaddr_q - cms_pkg::OFF_BANK_FIRST) >> 3);
      if (aw_take) begin
         aw_have_d = 1'b1;
         awaddr_d = s_axi_awaddr;
      end
      if (w_take) begin
         w_have_d = 1'b1;
         wdata_d = s_axi_wdata;
         wstrb_d = s_axi_wstrb;
      end
      if (do_write) begin
         aw_have_d = 1'b0;
         w_have_d = 1'b0;
         bvalid_d = 1'b1;
         bresp_d = cms_pkg::RESP_OKAY;
         if (awaddr_q >= cms_pkg::OFF_BANK_FIRST && awaddr_q <= cms_pkg::OFF_BANK_LAST &&
             32'(bidx) < NUM_BANKS && awaddr_q[1:0] == 2'h0) begin
            if (awaddr_q[2]) begin
               opt_d[bidx[2:0]] = merge(opt_q[bidx[2:0]], wdata_q, wstrb_q);
            end else begin
               base_d[bidx[2:0]] = merge(base_q[bidx[2:0]], wdata_q, wstrb_q);
            end
         end else begin
            case (awaddr_q)
               cms_pkg::OFF_MODULE_CONFIG: mcr_d = merge(mcr_q, wdata_q, wstrb_q);
               cms_pkg::OFF_SYS_PROTECT: system_protection_control_d = 8'(merge(32'(system_protection_control_q), wdata_q, wstrb_q));
               cms_pkg::OFF_PORT_E_ASSIGN: port_e_pin_assignment_d = 16'(merge(32'(port_e_pin_assignment_q), wdata_q, wstrb_q));
               cms_pkg::OFF_MEM_GLOBAL: gmr_d = merge(gmr_q, wdata_q, wstrb_q);
               cms_pkg::OFF_MEM_STATUS: status_d = status_q & ~merge(32'h0, wdata_q, wstrb_q);
               cms_pkg::OFF_WDOG_SERVICE: service = 1'b1;
               cms_pkg::OFF_STRAP_STATUS: bresp_d = cms_pkg::RESP_OKAY;
               default: bresp_d = cms_pkg::RESP_SLVERR;
            endcase
         end
      end
      // Hardware events win over a clear in the same cycle.
      if (wp_hit) begin
         status_d[cms_pkg::STAT_WPER] = 1'b1;
      end
      if (par_hit) begin
         status_d[cms_pkg::STAT_PER] = 1'b1;
      end
      if (ar_take) begin
         rvalid_d = 1'b1;
         rresp_d = cms_pkg::RESP_OKAY;
         rdata_d = 32'h0;
         if (s_axi_araddr >= cms_pkg::OFF_BANK_FIRST && s_axi_araddr <= cms_pkg::OFF_BANK_LAST &&
             32'((s_axi_araddr - cms_pkg::OFF_BANK_FIRST) >> 3) < NUM_BANKS && s_axi_araddr[1:0] == 2'h0) begin
            rdata_d = s_axi_araddr[2] ? opt_q[3'((s_axi_araddr - cms_pkg::OFF_BANK_FIRST) >> 3)]
                                      : base_q[3'((s_axi_araddr - cms_pkg::OFF_BANK_FIRST) >> 3)];
         end else begin
            case (s_axi_araddr)
               cms_pkg::OFF_MODULE_CONFIG: rdata_d = mcr_q;
               cms_pkg::OFF_SYS_PROTECT: rdata_d = 32'(system_protection_control_q);
               cms_pkg::OFF_PORT_E_ASSIGN: rdata_d = 32'(port_e_pin_assignment_q);
               cms_pkg::OFF_MEM_GLOBAL: rdata_d = gmr_q;
               cms_pkg::OFF_MEM_STATUS: rdata_d = status_q;
               cms_pkg::OFF_WDOG_SERVICE: rdata_d = 32'(wdog_q);
               cms_pkg::OFF_STRAP_STATUS: rdata_d = 32'(strap_q);
               default: rresp_d = cms_pkg::RESP_SLVERR;
            endcase
         end
      end
   end

   // ****************************************
   // Host cycle decode, interrupts, watchdog
   // ****************************************
   // Decode ignores the straps, so a slave-strapped secondary still answers on transfer start.
   always_comb begin
      cs_n_d = '1;
      ras_n_d = '1;
      burst_d = burst_clocks_q;
      wp_hit = 1'b0;
      last_bank_parity_enable_d = last_bank_parity_enable_q;
      for (int i = 0; i < NUM_BANKS; i++) begin
         if (transfer_start_pin && base_q[i][cms_pkg::BR_V] &&
             ((host_addr[31:11] ^ base_q[i][31:11]) & {4'hf, opt_q[i][27:11]}) == 21'h0 &&
             (opt_q[i][cms_pkg::OR_FCM_LO +: 4] == 4'h0 ? host_fc != cms_pkg::FC_CPU_SPACE :
              ((host_fc ^ base_q[i][cms_pkg::BR_FC_LO +: 4]) & opt_q[i][cms_pkg::OR_FCM_LO +: 4]) == 4'h0)) begin
            if (host_write && base_q[i][cms_pkg::BR_WP]) begin
               wp_hit = 1'b1;
            end else begin
               cs_n_d[i] = opt_q[i][cms_pkg::OR_DRAM_SELECT_BIT];
               ras_n_d[i] = !opt_q[i][cms_pkg::OR_DRAM_SELECT_BIT];
               burst_d = 3'(opt_q[i][cms_pkg::OR_BCYC_LO +: 2]) + 3'h1;
               last_bank_parity_enable_d = base_q[i][cms_pkg::BR_BANK_PARITY_ENABLE];
            end
         end
      end
      par_hit = parity_error_in && last_bank_parity_enable_q;
      bus_error_d = par_hit && gmr_q[cms_pkg::GMR_PARITY_BUS_ERROR_ENABLE];
      irq_level_d = (sim_irq_level >= cpm_irq_level) ? sim_irq_level : cpm_irq_level;
      irq_sim_d = (sim_irq_level > cpm_irq_level) || (sim_irq_level == cpm_irq_level &&
                  sim_irq_level != 3'h0 && mcr_q[cms_pkg::MCR_IARB_LO +: 4] == cms_pkg::IARB_TOP);
      wdog_d = wdog_q + 16'h1;
      wdog_irq_d = 1'b0;
      wdog_rst_d = 1'b0;
      if (!system_protection_control_q[cms_pkg::SYP_SWE] || service) begin
         wdog_d = 16'h0;
      end else if (wdog_q == 16'(WATCHDOG_CYCLES - 1)) begin
         wdog_d = 16'h0;
         wdog_rst_d = system_protection_control_q[cms_pkg::SYP_WATCHDOG_RESET_OR_INTERRUPT];
         wdog_irq_d = !system_protection_control_q[cms_pkg::SYP_WATCHDOG_RESET_OR_INTERRUPT];
      end
      strap_taken_d = 1'b1;
      strap_d = strap_taken_q ? strap_q : boot_configuration_straps;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         awaddr_q <= 8'h0;
         wdata_q <= cms_pkg::RESET_WORD;
         wstrb_q <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= cms_pkg::RESP_OKAY;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= cms_pkg::RESET_WORD;
         s_axi_rresp <= cms_pkg::RESP_OKAY;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_arready <= 1'b0;
         mcr_q <= cms_pkg::IARB_RESET;
         gmr_q <= cms_pkg::RESET_WORD;
         status_q <= cms_pkg::RESET_WORD;
         system_protection_control_q <= 8'h0;
         port_e_pin_assignment_q <= 16'h0;
         for (int i = 0; i < NUM_BANKS; i++) begin
            base_q[i] <= cms_pkg::RESET_WORD;
            opt_q[i] <= cms_pkg::RESET_WORD;
         end
         strap_q <= 3'h0;
         strap_taken_q <= 1'b0;
         wdog_q <= 16'h0;
         last_bank_parity_enable_q <= 1'b0;
         chip_select_n_q <= '1;
         row_strobe_n_q <= '1;
         burst_clocks_q <= 3'h1;
         bus_error_q <= 1'b0;
         irq_level_q <= 3'h0;
         irq_from_sim_q <= 1'b0;
         watchdog_irq_q <= 1'b0;
         watchdog_reset_q <= 1'b0;
         port_e_function_q <= 16'h0;
      end else begin
         aw_have_q <= aw_have_d;
         w_have_q <= w_have_d;
         awaddr_q <= awaddr_d;
         wdata_q <= wdata_d;
         wstrb_q <= wstrb_d;
         s_axi_bvalid <= bvalid_d;
         s_axi_bresp <= bresp_d;
         s_axi_rvalid <= rvalid_d;
         s_axi_rdata <= rdata_d;
         s_axi_rresp <= rresp_d;
         s_axi_awready <= !aw_have_d;
         s_axi_wready <= !w_have_d;
         s_axi_arready <= !rvalid_d;
         mcr_q <= mcr_d;
         gmr_q <= gmr_d;
         status_q <= status_d;
         system_protection_control_q <= system_protection_control_d;
         port_e_pin_assignment_q <= port_e_pin_assignment_d;
         base_q <= base_d;
         opt_q <= opt_d;
         strap_q <= strap_d;
         strap_taken_q <= strap_taken_d;
         wdog_q <= wdog_d;
         last_bank_parity_enable_q <= last_bank_parity_enable_d;
         chip_select_n_q <= cs_n_d;
         row_strobe_n_q <= ras_n_d;
         burst_clocks_q <= burst_d;
         bus_error_q <= bus_error_d;
         irq_level_q <= irq_level_d;
         irq_from_sim_q <= irq_sim_d;
         watchdog_irq_q <= wdog_irq_d;
         watchdog_reset_q <= wdog_rst_d;
         port_e_function_q <= port_e_pin_assignment_q;
      end
   end

   cms_refresh u_refresh (
      .aclk(aclk),
      .aresetn(aresetn),
      .enable(gmr_q[cms_pkg::GMR_REFRESH_ENABLE_BIT]),
      .interval(gmr_q[cms_pkg::GMR_REFRESH_INTERVAL_COUNT_LO +: 8]),
      .refresh_pulse_q(refresh_pulse_q)
   );

   // ****************************************
   // Checks
   // ****************************************
   sequence s_cpu_space_cycle;
      transfer_start_pin && host_fc == cms_pkg::FC_CPU_SPACE && opt_q[0][cms_pkg::OR_FCM_LO +: 4] == 4'h0;
   endsequence

   a_status_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
      status_q[cms_pkg::STAT_WPER] && !do_write |=> status_q[cms_pkg::STAT_WPER])
      else $error("status bit lost without clear");
   a_wp_records: assert property (@(posedge aclk) disable iff (!aresetn)
      wp_hit |=> status_q[cms_pkg::STAT_WPER] && chip_select_n_q == '1 && row_strobe_n_q == '1)
      else $error("write-protect hit not recorded");
   a_cpu_space_skip: assert property (@(posedge aclk) disable iff (!aresetn)
      s_cpu_space_cycle |=> chip_select_n_q[0] && row_strobe_n_q[0])
      else $error("bank 0 selected in CPU space");
   sequence s_two_clock_hit;
      transfer_start_pin && opt_q[1][cms_pkg::OR_BCYC_LO +: 2] == 2'h1 ##1 !row_strobe_n_q[1];
   endsequence

   sequence s_one_clock_hit;
      transfer_start_pin && opt_q[0][cms_pkg::OR_BCYC_LO +: 2] == 2'h0 ##1 !chip_select_n_q[0];
   endsequence

   // Judged from the host inputs and registers, not the strobes, so a decode slip shows up here too.
   sequence s_bank0_read_hit;
      transfer_start_pin && !host_write && base_q[0][cms_pkg::BR_V] && !opt_q[0][cms_pkg::OR_DRAM_SELECT_BIT] &&
      opt_q[0][cms_pkg::OR_FCM_LO +: 4] == 4'h0 && host_fc != cms_pkg::FC_CPU_SPACE &&
      opt_q[0][27:20] == 8'hff && opt_q[0][19:11] == 9'h0 && host_addr[31:20] == base_q[0][31:20];
   endsequence

   a_burst_length: assert property (@(posedge aclk) disable iff (!aresetn)
      s_two_clock_hit |-> burst_clocks_q == 3'h2)
      else $error("burst length wrong");
   a_burst_single: assert property (@(posedge aclk) disable iff (!aresetn)
      s_one_clock_hit |-> burst_clocks_q == 3'h1)
      else $error("single clock burst wrong");
   a_irq_tie_sim: assert property (@(posedge aclk) disable iff (!aresetn)
      sim_irq_level == cpm_irq_level && sim_irq_level != 3'h0 &&
      mcr_q[cms_pkg::MCR_IARB_LO +: 4] == cms_pkg::IARB_TOP |=> irq_from_sim_q && irq_level_q == $past(sim_irq_level))
      else $error("tie not won by system interrupt");
   a_wdog_reset: assert property (@(posedge aclk) disable iff (!aresetn)
      watchdog_irq_q || watchdog_reset_q |-> $past(system_protection_control_q[cms_pkg::SYP_SWE]) &&
      watchdog_reset_q == $past(system_protection_control_q[cms_pkg::SYP_WATCHDOG_RESET_OR_INTERRUPT]) && watchdog_irq_q != watchdog_reset_q)
      else $error("watchdog action wrong");
   a_pin_assign: assert property (@(posedge aclk) disable iff (!aresetn)
      do_write && awaddr_q == cms_pkg::OFF_PORT_E_ASSIGN && wstrb_q == 4'hf |-> ##2 port_e_function_q == $past(wdata_q[15:0], 2))
      else $error("pin assignment not applied");
   a_slave_decode: assert property (@(posedge aclk) disable iff (!aresetn)
      s_bank0_read_hit |=> !chip_select_n_q[0])
      else $error("host cycle not answered");
endmodule

/* tb/cms_host_model.sv */
`timescale 1ns/1ps
// ********************
// Host bus master
// ********************
module cms_host_model (
   input wire logic aclk,
   input wire logic go,
   input wire logic par,
   input wire logic [36:0] cyc,
   output logic transfer_start_pin,
   output logic [31:0] host_addr,
   output logic [3:0] host_fc,
   output logic host_write,
   output logic parity_error_in
);
   logic par_q;
   initial {transfer_start_pin, parity_error_in, par_q, host_addr, host_fc, host_write} = 40'h0;
   // Idle lines invert on every clock after the last cycle, so a stale address never hits by luck.
   always @(posedge aclk) begin
      parity_error_in <= transfer_start_pin & par_q;
      // One host is the only master and this block the only controller, so no arbiter is modelled.
      transfer_start_pin <= go;
      par_q <= go ? par : par_q;
      {host_addr, host_fc, host_write} <= go ? cyc : ~{host_addr, host_fc, host_write};
   end
endmodule

/* tb/tb_top.sv */
`timescale 1ns/1ps
// ********************
// Configuration bench
// ********************
module tb_top;
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready, h_go;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, transfer_start_pin, host_write, parity_error_in;
   logic bus_error_q, refresh_pulse_q, irq_from_sim_q, watchdog_irq_q, watchdog_reset_q, h_par;
   logic [7:0] s_axi_awaddr, s_axi_araddr, chip_select_n_q, row_strobe_n_q;
   logic [31:0] s_axi_wdata, s_axi_rdata, host_addr;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [3:0] host_fc;
   logic [2:0] sim_irq_level, cpm_irq_level, burst_clocks_q, irq_level_q;
   logic [15:0] port_e_function_q;
   logic [36:0] h_cyc;
   int fail_count = 0, n_tests = 0, be_seen = 0, wi_seen = 0;
   // Bus-clear ID 3 sits in an assumed field; the interrupt ID stays at 0xF.
   localparam logic [31:0] MCR_SETUP = 32'h0000300f;
   cms_top #(.WATCHDOG_CYCLES(16)) i_cms_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .transfer_start_pin, .host_addr, .host_fc, .host_write, .parity_error_in, .boot_configuration_straps(3'h5),
      .sim_irq_level, .cpm_irq_level, .chip_select_n_q, .row_strobe_n_q, .burst_clocks_q, .bus_error_q,
      .refresh_pulse_q, .irq_level_q, .irq_from_sim_q, .watchdog_irq_q, .watchdog_reset_q, .port_e_function_q);
   cms_host_model i_cms_host_model (.aclk, .go(h_go), .par(h_par), .cyc(h_cyc), .transfer_start_pin, .host_addr,
      .host_fc, .host_write, .parity_error_in);
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   always @(posedge aclk) be_seen += int'(bus_error_q === 1'b1);
   always @(posedge aclk) wi_seen += int'(watchdog_irq_q === 1'b1);
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      n_tests++;
      if (s !== e) $display("MISMATCH %s expected %h seen %h", nm, e, s);
      fail_count += int'(s !== e);
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
      @(posedge aclk) {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'h7};
      for (int n = 0; n < 50 && s_axi_bvalid !== 1'b1; n++)
         @(posedge aclk) {s_axi_awvalid, s_axi_wvalid} <= {s_axi_awvalid & ~s_axi_awready, s_axi_wvalid & ~s_axi_wready};
      s_axi_bready <= 1'b0;
      chk("bvalid", 1'b1, s_axi_bvalid);
      chk("bresp", e, s_axi_bresp);
   endtask
   task automatic axr(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      @(posedge aclk) {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
      for (int n = 0; n < 50 && s_axi_rvalid !== 1'b1; n++)
         @(posedge aclk) s_axi_arvalid <= s_axi_arvalid & ~s_axi_arready;
      s_axi_rready <= 1'b0;
      chk("rvalid", 1'b1, s_axi_rvalid);
      chk("rdata", e, s_axi_rdata);
      chk("rresp", er, s_axi_rresp);
   endtask
   task automatic host(input logic [36:0] c, input logic p, input logic [7:0] ecs, input logic [7:0] ers);
      @(posedge aclk) {h_go, h_par, h_cyc} <= {1'b1, p, c};
      @(posedge aclk) h_go <= 1'b0;
      @(posedge aclk) #1;
      chk("select", ecs, chip_select_n_q);
      chk("row_strobe", ers, row_strobe_n_q);
   endtask
   task automatic irq_step(input logic [2:0] s, input logic [2:0] c, input logic [2:0] el, input logic es);
      @(posedge aclk) {sim_irq_level, cpm_irq_level} <= {s, c};
      repeat (2) @(posedge aclk);
      #1;
      chk("irq_level", el, irq_level_q);
      chk("irq_sim", es, irq_from_sim_q);
   endtask
   task automatic t_regs();
      axr(8'h00, cms_pkg::IARB_RESET, 2'h0);
      axr(8'h10, 32'h0, 2'h0);
      axr(8'h1c, 32'h0, 2'h2);
      axw(8'hfc, 32'h1, 2'h2);
      axr(8'h18, 32'h5, 2'h0);
      axw(8'h00, MCR_SETUP, 2'h0);
      axr(8'h00, MCR_SETUP, 2'h0);
   endtask
   task automatic t_refresh();
      int n;
      axw(8'h0c, 32'h18800000, 2'h0);
      for (n = 0; n < 3000 && refresh_pulse_q !== 1'b1; n++) @(posedge aclk);
      @(posedge aclk);
      for (n = 1; n < 3000 && refresh_pulse_q !== 1'b1; n++) @(posedge aclk);
      chk("refresh_gap", 1560, n);
   endtask
   task automatic t_banks();
      axw(8'h20, 32'h00100001, 2'h0);
      axw(8'h24, 32'h0ff00000, 2'h0);
      axw(8'h28, 32'h00400005, 2'h0);
      axw(8'h2c, 32'h0fc00021, 2'h0);
      axw(8'h30, 32'h00800003, 2'h0);
      axw(8'h34, 32'h0ff00000, 2'h0);
      axw(8'h38, 32'h00a00001, 2'h0);
      axw(8'h3c, 32'h0fff8000, 2'h0);
      host({32'h00123450, 4'h5, 1'b0}, 1'b0, 8'hfe, 8'hff);
      chk("burst", 3'h1, burst_clocks_q);
      host({32'h00123450, 4'h7, 1'b0}, 1'b0, 8'hff, 8'hff);
      host({32'h00400010, 4'h5, 1'b0}, 1'b1, 8'hff, 8'hfd);
      chk("burst", 3'h2, burst_clocks_q);
      host({32'h00800000, 4'h5, 1'b0}, 1'b0, 8'hfb, 8'hff);
      host({32'h00800000, 4'h5, 1'b1}, 1'b0, 8'hff, 8'hff);
      host({32'h00a07ffc, 4'h1, 1'b0}, 1'b0, 8'hf7, 8'hff);
      host({32'h00a08000, 4'h1, 1'b0}, 1'b0, 8'hff, 8'hff);
   endtask
   task automatic t_status();
      axr(8'h10, 32'h3, 2'h0);
      axw(8'h10, 32'h3, 2'h0);
      axr(8'h10, 32'h0, 2'h0);
      host({32'h00100000, 4'h2, 1'b0}, 1'b1, 8'hfe, 8'hff);
      axr(8'h10, 32'h0, 2'h0);
      chk("bus_error", 0, be_seen);
      axw(8'h0c, 32'h18800010, 2'h0);
      host({32'h00400010, 4'h5, 1'b0}, 1'b1, 8'hff, 8'hfd);
      repeat (3) @(posedge aclk);
      chk("bus_error", 1, be_seen);
      axw(8'h0c, 32'h18800000, 2'h0);
   endtask
   task automatic t_irq();
      irq_step(3'h3, 3'h3, 3'h3, 1'b1);
      irq_step(3'h2, 3'h5, 3'h5, 1'b0);
   endtask
   task automatic t_port();
      axw(8'h08, 32'h000031c0, 2'h0);
      @(posedge aclk) #1;
      chk("port_e", 16'h31c0, port_e_function_q);
   endtask
   task automatic t_wdog();
      int n;
      axw(8'h04, 32'h000000c0, 2'h0);
      for (n = 0; n < 100 && watchdog_reset_q !== 1'b1; n++) @(posedge aclk);
      chk("wd_reset", 1'b1, watchdog_reset_q);
      chk("wd_irq", 0, wi_seen);
      axw(8'h04, 32'h00000080, 2'h0);
      for (n = 0; n < 100 && watchdog_irq_q !== 1'b1; n++) @(posedge aclk);
      chk("wd_irq_mode", 1'b1, watchdog_irq_q);
      axw(8'h14, 32'h0, 2'h0);
      axr(8'h14, 32'h2, 2'h0);
   endtask
   initial begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, h_go, h_par} = 8'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, h_cyc, sim_irq_level, cpm_irq_level} = 91'h0;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      t_regs();
      t_refresh();
      t_banks();
      t_status();
      t_irq();
      t_port();
      t_wdog();
      finish_test();
   end
   // The whole run needs some four thousand cycles, so twenty thousand means a hang.
   initial begin
      #200000;
      fail_count++;
      finish_test();
   end
endmodule
